// ### logic/cfg_lock_pkg.sv
package cfg_lock_pkg;
   // port map, full 16-bit addresses
   localparam logic [15:0] UNLOCK_PORT = 16'hF073;
   localparam logic [15:0] STATUS_PORT = 16'hFC72;
   localparam logic [15:0] EMS_PTR_PORT = 16'hE072;
   localparam logic [15:0] EMS_PAGE_PORT = 16'hE872;
   localparam logic [15:0] LOCK_FIRST_PORT = 16'h1072;
   localparam logic [15:0] LOCK_LAST_PORT = 16'hF872;
   // lockable ports share these low ten address bits
   localparam logic [9:0] LOCK_LOW_BITS = 10'h072;
   localparam int ADDR_BITS = 16;
   localparam int SHORT_ADDR_BITS = 10;

   // unlock key
   localparam logic [7:0] UNLOCK_KEY = 8'hDA;

   // status word layout
   localparam int TOGGLE_BIT = 15;
   localparam int DMA2_LSB = 8;
   localparam int DMA1_LSB = 4;
   localparam int LPT_DIR_BIT = 3;
   localparam int DMA_CHANNELS = 4;

   // reset values
   localparam logic RESET_TOGGLE = 1'b0;
   localparam logic [15:0] RESET_WORD = 16'h0000;

   // lock gate states, one-hot
   typedef enum logic [1:0] {
      GATE_LOCKED = 2'b01,
      GATE_UNLOCKED = 2'b10
   } gate_state_e;
endpackage

// ### logic/io_port_match.sv
`timescale 1ns/1ps
`default_nettype none
module io_port_match #(
   parameter int MATCH_BITS = 16
) (
   // compare
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_port,
   // result
   output logic o_hit
);
   // refused at elaboration, a wider compare would read past the address bus
   if (MATCH_BITS < 1 || MATCH_BITS > 16) begin : g_bad_width
      $error("io_port_match: MATCH_BITS must be 1..16");
   end

   // short ports ignore the upper address bits entirely
   always_comb begin
      o_hit = (i_addr[MATCH_BITS-1:0] == i_port[MATCH_BITS-1:0]);
   end
endmodule
`default_nettype wire

// ### logic/config_register_lock_gate.sv
`timescale 1ns/1ps
`default_nettype none
module config_register_lock_gate (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // host io cycle, one-cycle strobes
   input wire logic [15:0] i_io_addr,
   input wire logic [15:0] i_io_wdata,
   input wire logic i_io_rd,
   input wire logic i_io_wr,
   // mirrored state from neighbouring blocks
   input wire logic [3:0] i_dma1_mask,
   input wire logic [3:0] i_dma2_mask,
   input wire logic i_lpt_dir,
   // status read answer
   output logic [15:0] o_rd_data,
   output logic o_rd_ack,
   // internal register file access
   output logic o_reg_rd,
   output logic o_reg_wr,
   output logic [15:0] o_reg_addr,
   output logic [15:0] o_reg_wdata,
   // expansion bus forwarding
   output logic o_fwd_rd,
   output logic o_fwd_wr,
   // lock state
   output logic o_unlocked
);

   ////////////////////////////////////////////////////////////////////////////////
   // address decode

   logic hit_unlock;
   logic hit_status;
   logic hit_ems_ptr;
   logic hit_ems_page;
   logic hit_lock_low;
   logic lock_range;
   logic exempt;
   logic lockable;

   io_port_match #(.MATCH_BITS(cfg_lock_pkg::ADDR_BITS)) u_unlock_match (
      .i_addr(i_io_addr),
      .i_port(cfg_lock_pkg::UNLOCK_PORT),
      .o_hit(hit_unlock)
   );

   io_port_match #(.MATCH_BITS(cfg_lock_pkg::ADDR_BITS)) u_status_match (
      .i_addr(i_io_addr),
      .i_port(cfg_lock_pkg::STATUS_PORT),
      .o_hit(hit_status)
   );

   io_port_match #(.MATCH_BITS(cfg_lock_pkg::ADDR_BITS)) u_ems_ptr_match (
      .i_addr(i_io_addr),
      .i_port(cfg_lock_pkg::EMS_PTR_PORT),
      .o_hit(hit_ems_ptr)
   );

   io_port_match #(.MATCH_BITS(cfg_lock_pkg::ADDR_BITS)) u_ems_page_match (
      .i_addr(i_io_addr),
      .i_port(cfg_lock_pkg::EMS_PAGE_PORT),
      .o_hit(hit_ems_page)
   );

   // the low-bit comparison is only a grouping; the range check uses all 16 bits
   io_port_match #(.MATCH_BITS(cfg_lock_pkg::SHORT_ADDR_BITS)) u_lock_low_match (
      .i_addr(i_io_addr),
      .i_port({6'h00, cfg_lock_pkg::LOCK_LOW_BITS}),
      .o_hit(hit_lock_low)
   );

   always_comb begin
      lock_range = (i_io_addr >= cfg_lock_pkg::LOCK_FIRST_PORT) &&
                   (i_io_addr <= cfg_lock_pkg::LOCK_LAST_PORT);
      exempt = hit_ems_ptr || hit_ems_page;
      lockable = hit_lock_low && lock_range && !exempt;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // lock state

   cfg_lock_pkg::gate_state_e state_q;
   logic key_ok;
   logic unlocked;

   always_comb begin
      key_ok = (i_io_wdata[7:0] == cfg_lock_pkg::UNLOCK_KEY);
      unlocked = (state_q == cfg_lock_pkg::GATE_UNLOCKED);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         state_q <= cfg_lock_pkg::GATE_LOCKED;
      end else if (i_io_wr && hit_unlock) begin
         case (state_q)
            cfg_lock_pkg::GATE_LOCKED,
            cfg_lock_pkg::GATE_UNLOCKED: begin
               if (key_ok) begin
                  state_q <= cfg_lock_pkg::GATE_UNLOCKED;
               end else begin
                  state_q <= cfg_lock_pkg::GATE_LOCKED;
               end
            end
            default: begin
               state_q <= cfg_lock_pkg::GATE_LOCKED;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_unlocked <= 1'b0;
      end else if (i_io_wr && hit_unlock) begin
         o_unlocked <= key_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // status port

   logic toggle_q;
   logic status_rd;
   logic [15:0] status_word;

   // locked reads go out to the bus, so the flag holds still and software sees no toggle
   always_comb begin
      status_rd = i_io_rd && hit_status && unlocked;
      status_word = cfg_lock_pkg::RESET_WORD;
      status_word[cfg_lock_pkg::TOGGLE_BIT] = toggle_q;
      status_word[cfg_lock_pkg::DMA2_LSB +: cfg_lock_pkg::DMA_CHANNELS] = i_dma2_mask;
      status_word[cfg_lock_pkg::DMA1_LSB +: cfg_lock_pkg::DMA_CHANNELS] = i_dma1_mask;
      status_word[cfg_lock_pkg::LPT_DIR_BIT] = i_lpt_dir;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         toggle_q <= cfg_lock_pkg::RESET_TOGGLE;
      end else if (status_rd) begin
         toggle_q <= ~toggle_q;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_rd_data <= cfg_lock_pkg::RESET_WORD;
         o_rd_ack <= 1'b0;
      end else begin
         o_rd_ack <= status_rd;
         if (status_rd) begin
            o_rd_data <= status_word;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // routing

   logic pass_reg;
   logic go_fwd;
   logic status_fwd;

   always_comb begin
      // status port is served here, not by the register file
      pass_reg = exempt || (lockable && unlocked && !hit_status);
      go_fwd = lockable && !unlocked;
      // status port sits above the lock range but its reads are gated like the rest; its writes go nowhere
      status_fwd = hit_status && !unlocked;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_reg_rd <= 1'b0;
         o_reg_wr <= 1'b0;
         o_fwd_rd <= 1'b0;
         o_fwd_wr <= 1'b0;
      end else begin
         o_reg_rd <= i_io_rd && pass_reg;
         o_reg_wr <= i_io_wr && pass_reg;
         // write-only unlock port has nothing to read back
         o_fwd_rd <= i_io_rd && (go_fwd || hit_unlock || status_fwd);
         o_fwd_wr <= i_io_wr && go_fwd;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_reg_addr <= cfg_lock_pkg::RESET_WORD;
         o_reg_wdata <= cfg_lock_pkg::RESET_WORD;
      end else if ((i_io_rd || i_io_wr) && pass_reg) begin
         o_reg_addr <= i_io_addr;
         o_reg_wdata <= i_io_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   // last flag value handed out, kept only for the toggle check
   logic last_t_q;

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         last_t_q <= ~cfg_lock_pkg::RESET_TOGGLE;
      end else if (o_rd_ack) begin
         last_t_q <= o_rd_data[cfg_lock_pkg::TOGGLE_BIT];
      end
   end

   key_opens_gate_a: assert property (
      i_io_wr && i_io_addr == cfg_lock_pkg::UNLOCK_PORT &&
      i_io_wdata[7:0] == cfg_lock_pkg::UNLOCK_KEY |=> o_unlocked && state_q[1])
      else $error("key write did not unlock");

   bad_key_locks_a: assert property (
      i_io_wr && i_io_addr == cfg_lock_pkg::UNLOCK_PORT &&
      i_io_wdata[7:0] != cfg_lock_pkg::UNLOCK_KEY |=> !o_unlocked)
      else $error("wrong key left gate open");

   high_byte_free_a: assert property (
      i_io_wr && i_io_addr == cfg_lock_pkg::UNLOCK_PORT &&
      i_io_wdata[15:8] != 8'h00 && i_io_wdata[7:0] == cfg_lock_pkg::UNLOCK_KEY
      |=> o_unlocked)
      else $error("high byte affected unlock");

   alias_no_unlock_a: assert property (
      !o_unlocked && i_io_wr && i_io_addr[9:0] == cfg_lock_pkg::UNLOCK_PORT[9:0] &&
      i_io_addr != cfg_lock_pkg::UNLOCK_PORT |=> !o_unlocked)
      else $error("partial address unlocked gate");

   ems_always_open_a: assert property (
      i_io_wr && (i_io_addr == cfg_lock_pkg::EMS_PTR_PORT ||
      i_io_addr == cfg_lock_pkg::EMS_PAGE_PORT) |=> o_reg_wr && !o_fwd_wr &&
      o_reg_addr == $past(i_io_addr))
      else $error("ems port not passed");

   locked_read_fwd_a: assert property (
      i_io_rd && !o_unlocked && i_io_addr == 16'h3872 |=> o_fwd_rd && !o_reg_rd && !o_rd_ack)
      else $error("locked read not forwarded");

   locked_write_fwd_a: assert property (
      i_io_wr && !o_unlocked && i_io_addr == 16'h1872 |=> o_fwd_wr && !o_reg_wr)
      else $error("locked write reached register");

   toggle_flip_a: assert property (
      o_rd_ack |-> o_rd_data[cfg_lock_pkg::TOGGLE_BIT] != last_t_q)
      else $error("toggle flag did not invert");

   status_answer_a: assert property (
      i_io_rd && i_io_addr == cfg_lock_pkg::STATUS_PORT && o_unlocked
      |=> o_rd_ack && !o_fwd_rd)
      else $error("unlocked status read not answered");

   locked_status_fwd_a: assert property (
      i_io_rd && i_io_addr == cfg_lock_pkg::STATUS_PORT && !o_unlocked
      |=> o_fwd_rd && !o_rd_ack)
      else $error("locked status read not forwarded");

   no_double_route_a: assert property (
      !(o_reg_wr && o_fwd_wr) && !(o_reg_rd && o_fwd_rd))
      else $error("access routed both ways");

   status_layout_a: assert property (
      o_rd_ack |-> o_rd_data[11:8] == $past(i_dma2_mask) &&
      o_rd_data[7:4] == $past(i_dma1_mask) && o_rd_data[3] == $past(i_lpt_dir) &&
      o_rd_data[14:12] == 3'h0 && o_rd_data[2:0] == 3'h0)
      else $error("status word layout wrong");

   reset_locked_a: assert property (
      $past(i_rst) |-> !o_unlocked && !o_rd_ack && !o_fwd_rd)
      else $error("gate not locked after reset");

   unlock_seen_c: cover property (
      !o_unlocked ##1 o_unlocked);

   status_twice_c: cover property (
      o_rd_ack ##[1:4] o_rd_ack);

   locked_fwd_c: cover property (
      o_fwd_wr && !o_unlocked);

   relock_c: cover property (
      o_unlocked ##1 !o_unlocked);

   ems_locked_c: cover property (
      o_reg_wr && !o_unlocked);
endmodule
`default_nettype wire

// ### verification/io_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module io_host_model (
   // clock
   input wire logic i_ref_clk,
   // status answer
   input wire logic [15:0] i_rd_data,
   input wire logic i_rd_ack,
   // host io cycle
   output logic [15:0] o_io_addr,
   output logic [15:0] o_io_wdata,
   output logic o_io_rd,
   output logic o_io_wr
);
   initial begin
      o_io_addr = 16'h0000;
      o_io_wdata = 16'h0000;
      o_io_rd = 1'b0;
      o_io_wr = 1'b0;
   end
   task automatic cycle(input logic rd, input logic [15:0] addr, input logic [15:0] data);
      @(posedge i_ref_clk);
      #1;
      o_io_rd = rd;
      o_io_wr = ~rd;
      o_io_addr = addr;
      o_io_wdata = data;
   endtask
   // released bus shows the inverse, so a stale decode cannot match by luck
   task automatic idle();
      @(posedge i_ref_clk);
      #1;
      o_io_rd = 1'b0;
      o_io_wr = 1'b0;
      o_io_addr = ~o_io_addr;
      o_io_wdata = ~o_io_wdata;
   endtask
   // two status reads back to back; a flipping top bit means open
   task automatic lock_probe(output logic unl);
      logic a0;
      logic t0;
      cycle(1'b1, cfg_lock_pkg::STATUS_PORT, 16'h0000);
      cycle(1'b1, cfg_lock_pkg::STATUS_PORT, 16'h0000);
      a0 = i_rd_ack;
      t0 = i_rd_data[15];
      idle();
      unl = (a0 === 1'b1) && (i_rd_ack === 1'b1) && (t0 !== i_rd_data[15]);
   endtask
endmodule
`default_nettype wire

// ### verification/config_register_lock_gate_tb.sv
`timescale 1ns/1ps
`default_nettype none
module config_register_lock_gate_tb;
   logic clk, rst, rd, wr, rd_ack, reg_rd, reg_wr, fwd_rd, fwd_wr, unl, lpt, got, was_rst;
   logic [15:0] addr, wdata, rd_data, reg_addr, reg_wdata;
   logic [31:0] r;
   logic [3:0] dma1, dma2;
   int n_fail, n_compared, n;
   logic m_lk, m_tg, e_ack, e_rrd, e_rwr, e_frd, e_fwr;
   logic [15:0] e_data, e_addr, e_wdata;
   logic [15:0] pool [9] = '{16'h1072, 16'h3872, 16'hF472, 16'hF872, 16'hE072, 16'hE872,
                             16'h0072, 16'hE073, 16'hFC72};
   config_register_lock_gate dut_u (.i_ref_clk(clk), .i_rst(rst), .i_io_addr(addr),
      .i_io_wdata(wdata), .i_io_rd(rd), .i_io_wr(wr), .i_dma1_mask(dma1), .i_dma2_mask(dma2),
      .i_lpt_dir(lpt), .o_rd_data(rd_data), .o_rd_ack(rd_ack), .o_reg_rd(reg_rd),
      .o_reg_wr(reg_wr), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .o_fwd_rd(fwd_rd),
      .o_fwd_wr(fwd_wr), .o_unlocked(unl));
   io_host_model host_u (.i_ref_clk(clk), .i_rd_data(rd_data), .i_rd_ack(rd_ack),
      .o_io_addr(addr), .o_io_wdata(wdata), .o_io_rd(rd), .o_io_wr(wr));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic lockable(input logic [15:0] a);
      return a[9:0] == 10'h072 && a >= 16'h1072 && a <= 16'hF872 && a != 16'hE072 &&
         a != 16'hE872;
   endfunction
   task automatic chk_bit(input logic g, input logic e, input string s);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR t=%0t %s got %b exp %b", $time, s, g, e);
      end
   endtask
   task automatic chk_word(input logic [15:0] g, input logic [15:0] e, input string s);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR t=%0t %s got %h exp %h", $time, s, g, e);
      end
   endtask
   task automatic conclude();
      if (n_fail == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // reference: state follows each taken request, outputs compared once settled
   always @(posedge clk) begin
      {e_ack, e_rrd, e_rwr, e_frd, e_fwr} = 5'h00;
      was_rst = rst;
      if (rst) begin
         {m_lk, m_tg, e_data, e_addr, e_wdata} = 50'h0;
      end else if (wr && addr == cfg_lock_pkg::UNLOCK_PORT) begin
         m_lk = (wdata[7:0] == cfg_lock_pkg::UNLOCK_KEY);
      end else if (rd && addr == cfg_lock_pkg::UNLOCK_PORT) begin
         e_frd = 1'b1;
      end else if (addr == cfg_lock_pkg::STATUS_PORT) begin
         if (rd && m_lk) begin
            e_ack = 1'b1;
            e_data = {m_tg, 3'h0, dma2, dma1, lpt, 3'h0};
            m_tg = ~m_tg;
         end else begin
            e_frd = rd;
         end
      end else if ((rd || wr) && (addr == cfg_lock_pkg::EMS_PTR_PORT ||
            addr == cfg_lock_pkg::EMS_PAGE_PORT || (m_lk && lockable(addr)))) begin
         {e_rrd, e_rwr, e_addr} = {rd, wr, addr};
         if (wr) begin
            e_wdata = wdata;
         end
      end else if (lockable(addr)) begin
         {e_frd, e_fwr} = {rd, wr};
      end
      #2;
      chk_bit(unl, m_lk, "lock");
      chk_bit(fwd_rd, e_frd, "fwd rd");
      chk_bit(fwd_wr, e_fwr, "fwd wr");
      chk_bit(reg_rd, e_rrd, "reg rd");
      chk_bit(reg_wr, e_rwr, "reg wr");
      chk_bit(rd_ack, e_ack, "ack");
      chk_word(rd_data, e_data, "status");
      chk_word(reg_addr, e_addr, "reg addr");
      if (e_rwr || was_rst) begin
         chk_word(reg_wdata, e_wdata, "reg data");
      end
   end
   // mirror inputs move every cycle
   always @(posedge clk) begin
      #1;
      {dma1, dma2, lpt} = 9'($urandom);
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic sweep();
      foreach (pool[i]) begin
         host_u.cycle(1'b0, pool[i], 16'($urandom));
         host_u.cycle(1'b1, pool[i], 16'h0000);
      end
      host_u.idle();
   endtask
   task automatic probe(input logic e);
      host_u.lock_probe(got);
      chk_bit(got, e, "probe");
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      conclude();
   end
   initial begin
      n = $urandom(32'h739A);
      {rst, n_fail, n_compared, dma1, dma2, lpt} = {1'b1, 64'h0, 9'h000};
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      probe(1'b0);
      sweep();
      host_u.cycle(1'b0, 16'hE073, 16'h00DA);
      r = $urandom;
      host_u.cycle(1'b0, cfg_lock_pkg::UNLOCK_PORT, {r[15:8], cfg_lock_pkg::UNLOCK_KEY});
      probe(1'b1);
      sweep();
      host_u.cycle(1'b0, cfg_lock_pkg::UNLOCK_PORT, 16'hDADB);
      probe(1'b0);
      repeat (400) begin
         r = $urandom;
         host_u.cycle(r[0], r[2:1] == 2'h0 ? cfg_lock_pkg::UNLOCK_PORT : r[2:1] == 2'h1 ?
            r[31:16] : pool[r[7:4] % 9], r[3] ? {r[31:24], cfg_lock_pkg::UNLOCK_KEY} : r[31:16]);
      end
      host_u.idle();
      host_u.cycle(1'b0, cfg_lock_pkg::UNLOCK_PORT, 16'h00DA);
      host_u.idle();
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      probe(1'b0);
      conclude();
   end
endmodule
`default_nettype wire
